/* cbt_term_ctrl.sv */
// How it works
// - three-bit value field selects termination, reset off
// - terminate only clock, chip select, six CA
// - LPDDR4 keeps termination through power-down states
// - LPDDR4 pad low: never terminate CA
// - LPDDR4 pad low: CK, CS follow enables
// - LPDDR4 pad high: CK, CS on; CA unless disabled
// - bond pad state unchanged entering power-down
// - LPDDR4X decides from mode registers only
// - LPDDR4X: three active-high per-line disable bits
// - pull-up point change needs recalibration
// - codes 001..110 decode to 240..40 ohms
`timescale 1ns/10ps
`default_nettype none

`include "cbt_params.svh"

module cbt_term_ctrl
    import cbt_pkg::*;
#(
    parameter int CA_LINES = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_lp4x_variant,
    input wire logic i_multirank_term_bond_pad,
    input wire logic i_power_down,
    input wire logic i_value_reg_wr,
    input wire logic [7:0] i_value_reg_data,
    input wire logic i_ctrl_reg_wr,
    input wire logic [7:0] i_ctrl_reg_data,
    input wire logic i_pu_cal_high,
    input wire logic i_zq_cal_done,
    output logic [CA_LINES-1:0] o_ca_term_en,
    output logic o_ck_term_en,
    output logic o_cs_term_en,
    output logic [7:0] o_term_rtt_ohms,
    output logic o_forbidden_combination,
    output logic o_recal_required,
    output logic [7:0] o_term_value_mode_reg,
    output logic [7:0] o_term_control_mode_reg
);

    // ======================================================
    // bond pad synchronise and capture
    logic pad_sync;
    logic pad_held;
    logic [1:0] pad_settle;
    logic next_pad_held;
    logic [1:0] next_pad_settle;

    cbt_sync2 #(
        .WIDTH(1)
    ) u_pad_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_async(i_multirank_term_bond_pad),
        .o_sync(pad_sync)
    );

    // pad is a static strap: caught once after reset release,
    // so no power state can ever disturb it
    always_comb begin
        next_pad_held = pad_held;
        next_pad_settle = pad_settle;
        if (i_clk_en && pad_settle != `CBT_PAD_SETTLE) begin
            next_pad_settle = pad_settle + `CBT_PAD_STEP;
            next_pad_held = pad_sync;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pad_held <= 1'b0;
            pad_settle <= `CBT_PAD_ZERO;
        end else begin
            pad_held <= next_pad_held;
            pad_settle <= next_pad_settle;
        end
    end

    // ======================================================
    // mode registers
    logic [7:0] next_value_reg;
    logic [7:0] next_ctrl_reg;

    // writes land in one cycle; decode below follows next value
    always_comb begin
        next_value_reg = o_term_value_mode_reg;
        next_ctrl_reg = o_term_control_mode_reg;
        if (i_clk_en && i_value_reg_wr) begin
            next_value_reg = i_value_reg_data;
        end
        if (i_clk_en && i_ctrl_reg_wr) begin
            next_ctrl_reg = i_ctrl_reg_data;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_term_value_mode_reg <= `CBT_VALUE_REG_RST;
            o_term_control_mode_reg <= `CBT_CTRL_REG_RST;
        end else begin
            o_term_value_mode_reg <= next_value_reg;
            o_term_control_mode_reg <= next_ctrl_reg;
        end
    end

    // ======================================================
    // termination decode
    cbt_rtt_code_e code;
    cbt_variant_e variant;
    logic value_on;
    logic ca_disable_bit;
    logic ck_bit;
    logic cs_bit;
    logic ca_on;
    logic next_ck_term;
    logic next_cs_term;
    logic [CA_LINES-1:0] next_ca_term;
    logic [7:0] next_rtt_ohms;
    logic next_forbidden;

    // i_power_down is deliberately not an input to this decode
    always_comb begin
        code = cbt_rtt_code_e'(
            next_value_reg[`CBT_VALUE_MSB:`CBT_VALUE_LSB]);
        variant = cbt_variant_e'(i_lp4x_variant);
        ca_disable_bit = next_ctrl_reg[`CBT_CA_DISABLE_BIT];
        ck_bit = next_ctrl_reg[`CBT_CK_ENABLE_BIT];
        cs_bit = next_ctrl_reg[`CBT_CS_ENABLE_BIT];
        value_on = 1'b0;
        next_rtt_ohms = `CBT_OHM_NONE;
        unique case (code)
            CBT_RTT_OFF: next_rtt_ohms = `CBT_OHM_NONE;
            CBT_RTT_240: next_rtt_ohms = `CBT_OHM_240;
            CBT_RTT_120: next_rtt_ohms = `CBT_OHM_120;
            CBT_RTT_80: next_rtt_ohms = `CBT_OHM_80;
            CBT_RTT_60: next_rtt_ohms = `CBT_OHM_60;
            CBT_RTT_48: next_rtt_ohms = `CBT_OHM_48;
            CBT_RTT_40: next_rtt_ohms = `CBT_OHM_40;
            CBT_RTT_RSV: next_rtt_ohms = `CBT_OHM_NONE;
        endcase
        value_on = (next_rtt_ohms != `CBT_OHM_NONE);
        ca_on = 1'b0;
        next_ck_term = 1'b0;
        next_cs_term = 1'b0;
        if (!value_on) begin
            ca_on = 1'b0;
            next_ck_term = 1'b0;
            next_cs_term = 1'b0;
        end else if (variant == CBT_LP4X) begin
            // enable bits read as disables in this variant
            ca_on = !ca_disable_bit;
            next_ck_term = !ck_bit;
            next_cs_term = !cs_bit;
        end else if (!pad_held) begin
            ca_on = 1'b0;
            next_ck_term = ck_bit;
            next_cs_term = cs_bit;
        end else begin
            ca_on = !ca_disable_bit;
            next_ck_term = 1'b1;
            next_cs_term = 1'b1;
        end
        next_ca_term = {CA_LINES{ca_on}};
        // high pull-up point pairs only with some values
        next_forbidden = 1'b0;
        if (value_on && i_pu_cal_high) begin
            if (variant == CBT_LP4X) begin
                next_forbidden = !(code == CBT_RTT_120 ||
                    code == CBT_RTT_60);
            end else begin
                next_forbidden = (code == CBT_RTT_60 ||
                    code == CBT_RTT_48 || code == CBT_RTT_40);
            end
        end
        if (!i_clk_en) begin
            next_ca_term = o_ca_term_en;
            next_ck_term = o_ck_term_en;
            next_cs_term = o_cs_term_en;
            next_rtt_ohms = o_term_rtt_ohms;
            next_forbidden = o_forbidden_combination;
        end
    end

    // termination stays on through power-down and self-refresh
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ca_term_en <= '0;
            o_ck_term_en <= 1'b0;
            o_cs_term_en <= 1'b0;
            o_term_rtt_ohms <= `CBT_OHM_NONE;
            o_forbidden_combination <= 1'b0;
        end else begin
            o_ca_term_en <= next_ca_term;
            o_ck_term_en <= next_ck_term;
            o_cs_term_en <= next_cs_term;
            o_term_rtt_ohms <= next_rtt_ohms;
            o_forbidden_combination <= next_forbidden;
        end
    end

    // ======================================================
    // recalibration tracking
    logic cal_point;
    logic next_cal_point;
    logic next_recal;

    // value changes never need recal; only the pull-up point.
    // a cal done in the same cycle as a point change wins
    always_comb begin
        next_cal_point = cal_point;
        next_recal = o_recal_required;
        if (i_clk_en) begin
            if (i_zq_cal_done) begin
                next_cal_point = i_pu_cal_high;
            end
            next_recal = (i_pu_cal_high != next_cal_point);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cal_point <= 1'b0;
            o_recal_required <= 1'b0;
        end else begin
            cal_point <= next_cal_point;
            o_recal_required <= next_recal;
        end
    end

endmodule // cbt_term_ctrl

`default_nettype wire

/* cbt_params.svh */
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// ==========================================================
// mode register reset values
`define CBT_VALUE_REG_RST 8'h00
`define CBT_CTRL_REG_RST 8'h00

// ==========================================================
// field positions
`define CBT_VALUE_MSB 6
`define CBT_VALUE_LSB 4
`define CBT_CK_ENABLE_BIT 3
`define CBT_CS_ENABLE_BIT 4
`define CBT_CA_DISABLE_BIT 5

// ==========================================================
// decoded termination resistance in ohms
`define CBT_OHM_NONE 8'h00
`define CBT_OHM_240 8'hF0
`define CBT_OHM_120 8'h78
`define CBT_OHM_80 8'h50
`define CBT_OHM_60 8'h3C
`define CBT_OHM_48 8'h30
`define CBT_OHM_40 8'h28

// ==========================================================
// pad capture settle count: two synchroniser stages, then one
// capture edge, since the stages come out of reset at zero
`define CBT_PAD_SETTLE 2'h3
`define CBT_PAD_STEP 2'h1
`define CBT_PAD_ZERO 2'h0

`endif

/* cbt_pkg.sv */
package cbt_pkg;

    // ======================================================
    // device variant
    typedef enum logic [0:0] {
        CBT_LP4 = 1'b0,
        CBT_LP4X = 1'b1
    } cbt_variant_e;

    // ======================================================
    // termination value field codes
    typedef enum logic [2:0] {
        CBT_RTT_OFF = 3'h0,
        CBT_RTT_240 = 3'h1,
        CBT_RTT_120 = 3'h2,
        CBT_RTT_80 = 3'h3,
        CBT_RTT_60 = 3'h4,
        CBT_RTT_48 = 3'h5,
        CBT_RTT_40 = 3'h6,
        CBT_RTT_RSV = 3'h7
    } cbt_rtt_code_e;

endpackage

/* cbt_sync2.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// two-flop synchroniser for pin inputs
module cbt_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // first stage is read only by the second stage
    always_comb begin
        next_meta = i_clk_en ? i_async : meta;
        next_sync = i_clk_en ? meta : o_sync;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end

endmodule // cbt_sync2

`default_nettype wire

/* cbt_term_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checks for the termination decode
module cbt_term_ctrl_sva
    import cbt_pkg::*;
#(
    parameter int CA_LINES = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_lp4x_variant,
    input wire logic i_value_reg_wr,
    input wire logic [7:0] i_value_reg_data,
    input wire logic i_pu_cal_high,
    input wire logic i_zq_cal_done,
    input wire logic [CA_LINES-1:0] o_ca_term_en,
    input wire logic o_ck_term_en,
    input wire logic o_cs_term_en,
    input wire logic [7:0] o_term_rtt_ohms,
    input wire logic o_forbidden_combination,
    input wire logic o_recal_required,
    input wire logic [7:0] o_term_value_mode_reg,
    input wire logic [7:0] o_term_control_mode_reg
);
    logic [2:0] code;
    logic on;
    logic [2:0] dis;
    logic [2:0] term;
    // readback registers stand for the decoder's own copy
    assign code = o_term_value_mode_reg[6:4];
    assign on = code != CBT_RTT_OFF && code != CBT_RTT_RSV;
    assign dis = {o_term_control_mode_reg[5], o_term_control_mode_reg[3],
        o_term_control_mode_reg[4]};
    assign term = {o_ca_term_en[0], o_ck_term_en, o_cs_term_en};
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    property p_wr;
        i_value_reg_wr && i_clk_en |=> o_term_value_mode_reg == $past(i_value_reg_data);
    endproperty
    a_wr: assert property (p_wr) else $error("value write lost");
    property p_off;
        !on |-> term == 3'h0 && o_term_rtt_ohms == 8'h00;
    endproperty
    a_off: assert property (p_off) else $error("term on when off");
    property p_eq;
        o_ca_term_en == '0 || o_ca_term_en == '1;
    endproperty
    a_eq: assert property (p_eq) else $error("ca lines differ");
    // variant and pull-up reach the outputs one edge late
    property p_x;
        $past(i_lp4x_variant && i_clk_en) && on |-> term == ~dis;
    endproperty
    a_x: assert property (p_x) else $error("lp4x disable bits");
    property p_lp4;
        $past(!i_lp4x_variant && i_clk_en) && term[2] |-> term == 3'h7;
    endproperty
    a_lp4: assert property (p_lp4) else $error("lp4 ca without ck cs");
    property p_ohm;
        code == CBT_RTT_60 |-> o_term_rtt_ohms == 8'h3C;
    endproperty
    a_ohm: assert property (p_ohm) else $error("ohm decode");
    property p_cal;
        i_zq_cal_done && i_clk_en |=> !o_recal_required;
    endproperty
    a_cal: assert property (p_cal) else $error("recal not cleared");
    property p_forb;
        $past(i_lp4x_variant && i_pu_cal_high && i_clk_en)
            && code == CBT_RTT_80 |-> o_forbidden_combination;
    endproperty
    a_forb: assert property (p_forb) else $error("forbidden missed");
    c_ca_off: cover property (o_ck_term_en && !o_ca_term_en[0]);
    c_forb: cover property (o_forbidden_combination);
    c_recal: cover property (o_recal_required);
endmodule // cbt_term_ctrl_sva
`default_nettype wire

/* cbt_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// controller model: mode register writes
module cbt_ctrl_model (
    input wire logic i_ref_clk,
    output logic o_value_reg_wr,
    output logic [7:0] o_value_reg_data,
    output logic o_ctrl_reg_wr,
    output logic [7:0] o_ctrl_reg_data
);
    // idle bus at time zero
    initial begin
        o_value_reg_wr = 1'b0;
        o_ctrl_reg_wr = 1'b0;
        o_value_reg_data = 8'h00;
        o_ctrl_reg_data = 8'h00;
    end
    // per-line bits first, value field last
    task automatic wr(input logic [7:0] v, input logic [7:0] c);
        @(posedge i_ref_clk);
        o_ctrl_reg_wr <= 1'b1;
        o_ctrl_reg_data <= c;
        @(posedge i_ref_clk);
        o_ctrl_reg_wr <= 1'b0;
        o_ctrl_reg_data <= ~c; // released bus is not the old word
        o_value_reg_wr <= 1'b1;
        o_value_reg_data <= v;
        @(posedge i_ref_clk);
        o_value_reg_wr <= 1'b0;
        o_value_reg_data <= ~v;
    endtask
endmodule // cbt_ctrl_model
`default_nettype wire

/* ca_bus_termination_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// termination decode bench
module ca_bus_termination_control_test;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic en = 1'b1;
    logic vr = 1'b0;
    logic pad = 1'b0;
    logic pd = 1'b0;
    logic pu = 1'b0;
    logic cal = 1'b0;
    logic vwr, cwr, ck, cs, forb, recal;
    logic [7:0] vd, cd, ohms, vrb, crb;
    logic [5:0] ca;
    logic [16:0] got;
    logic [16:0] e;
    int failures = 0;
    int cmp_count = 0;
    assign got = {ca, ck, cs, forb, ohms};
    always #20 i_ref_clk = ~i_ref_clk;
    cbt_ctrl_model ctl (.i_ref_clk, .o_value_reg_wr(vwr),
        .o_value_reg_data(vd), .o_ctrl_reg_wr(cwr), .o_ctrl_reg_data(cd));
    cbt_term_ctrl uut (.i_ref_clk, .i_sys_rst, .i_clk_en(en),
        .i_lp4x_variant(vr), .i_multirank_term_bond_pad(pad),
        .i_power_down(pd), .i_value_reg_wr(vwr), .i_value_reg_data(vd),
        .i_ctrl_reg_wr(cwr), .i_ctrl_reg_data(cd), .i_pu_cal_high(pu),
        .i_zq_cal_done(cal), .o_ca_term_en(ca), .o_ck_term_en(ck),
        .o_cs_term_en(cs), .o_term_rtt_ohms(ohms),
        .o_forbidden_combination(forb), .o_recal_required(recal),
        .o_term_value_mode_reg(vrb), .o_term_control_mode_reg(crb));
    // i: [6] variant, [5:3] value code, [2:0] ca/cs/ck control bits
    function automatic logic [16:0] expv(logic p, u, logic [6:0] i);
        logic on, ca_x, ck_x, cs_x, f;
        logic [2:0] c;
        c = i[5:3];
        on = c != 3'h0 && c != 3'h7;
        ca_x = on && !i[2] && (i[6] || p);
        ck_x = on && (i[6] ? !i[0] : p || i[0]);
        cs_x = on && (i[6] ? !i[1] : p || i[1]);
        f = on && u && (i[6] ? c != 3'h2 && c != 3'h4 : c > 3'h3);
        return {{6{ca_x}}, ck_x, cs_x, f, on ? 8'(240 / c) : 8'h00};
    endfunction
    task automatic chk(input logic [16:0] g, input logic [16:0] x);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic stop_test;
        $display("failures %0d cmp_count %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // pad is a strap: a fresh reset for each level
    initial begin
        // terminating die (pad high) is brought up first
        for (int p = 1; p >= 0; p--) begin
            i_sys_rst <= 1'b1;
            pad <= p[0];
            repeat (3) @(posedge i_ref_clk);
            i_sys_rst <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            #1 chk(got, 17'h0);
            // pad moves after capture; the latched strap must not
            pad <= ~p[0];
            for (int u = 0; u < 2; u++) begin
                pu <= u[0];
                repeat (2) @(posedge i_ref_clk);
                #1 chk(17'(recal), 17'(u[0]));
                @(posedge i_ref_clk);
                cal <= 1'b1;
                @(posedge i_ref_clk);
                cal <= 1'b0;
                #1 chk(17'(recal), 17'h0);
                for (int i = 0; i < 128; i++) begin
                    @(posedge i_ref_clk);
                    vr <= i[6];
                    pd <= i[0];
                    ctl.wr({1'b0, i[5:3], 4'h0}, {2'b00, i[2:0], 3'h0});
                    e = expv(p[0], u[0], i[6:0]);
                    #1 chk(got, e);
                end
                chk(17'(recal), 17'h0);
            end
        end
        @(posedge i_ref_clk);
        en <= 1'b0;
        ctl.wr(8'h20, 8'h00);
        #1 chk(17'({crb, vrb}), 17'h03870);
        en <= 1'b1;
        stop_test();
    end
    // a hang costs far more than the ~2080 cycles of the run
    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule // ca_bus_termination_control_test
bind cbt_term_ctrl cbt_term_ctrl_sva #(.CA_LINES(CA_LINES)) u_sva (
    .i_ref_clk, .i_sys_rst, .i_clk_en, .i_lp4x_variant, .i_value_reg_wr,
    .i_value_reg_data, .i_pu_cal_high, .i_zq_cal_done, .o_ca_term_en,
    .o_ck_term_en, .o_cs_term_en, .o_term_rtt_ohms,
    .o_forbidden_combination, .o_recal_required, .o_term_value_mode_reg,
    .o_term_control_mode_reg);
`default_nettype wire
